// ===== hdl/scw_device.sv
// slave end: selection detect, wake cause, memory buffer and stream modes
// assumes: link lines are asynchronous to clk_sys and the sclk is slow
// enough for the sampled edges (at least 6 clk_sys per half period)
//
// Functional notes
// - internal timing uses oversample field bits 3:0
// - master oversample factor limited to 4..16
// - software picks master factor 6..16
// - late sampling bit resets to zero
// - slave ignores oversample, follows serial clock
// - master keeps clock ratio within limits
// - external clocking only as slave
// - memory mode addressable, else stream bytes
// - standard submode, all four clock modes
// - external memory mode up to 48 Mbps
// - select clock field picks selection domain
// - operation clock field picks transfer domain
// - stream mode keeps operation clock internal
// - both internal: no deep sleep service
// - external select, internal operation run together
// - external select sets wake cause bit
// - mask kept clear in active mode
// - deep sleep with internal operation clock refuses transfer with all ones
// - receive filter applies three-tap majority
// - invalid memory-mode combination gives no response
`timescale 1ns/10ps
module scw_device
  import scw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link
  scw_if.dev link,
  // configuration
  input wire logic masterMode,
  input wire logic memBufMode,
  input wire logic selectClockSource,
  input wire logic operationClockSource,
  input wire logic [scw_pkg::FCT_W-1:0] oversampleFactor,
  input wire logic lateSample,
  input wire logic rxFilter,
  input wire logic cpol,
  input wire logic cpha,
  // power and wake
  input wire logic [1:0] powerMode,
  input wire logic wakeMask,
  input wire logic wakeClear,
  output logic wakeCause_r,
  output logic wakeIrq_r,
  // stream mode bytes
  input wire logic [7:0] txData,
  output logic [7:0] rxData_r,
  output logic rxValid_r,
  // memory user port
  input wire logic [scw_pkg::MEM_AW-1:0] memAddr,
  input wire logic [7:0] memWrData,
  input wire logic memWr,
  output logic [7:0] memRdData_r,
  // status
  output logic [4:0] factorInUse_r,
  output logic lateInUse_r
);
  import scw_pkg::*;

  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] h1;
    logic [2:0] h2;
    logic [2:0] prev;
    scw_dst_type st;
    logic [3:0] bitCnt;
    logic [7:0] rxSh;
    logic [7:0] txSh;
    logic [MEM_AW-1:0] ptr;
    logic wrXfer;
    logic addrPhase;
    logic wakeCause;
    logic wakeIrq;
    logic misoDrv;
    logic misoOe;
    logic [7:0] rxData;
    logic rxValid;
    logic [4:0] factorInUse;
    logic lateInUse;
    logic memWe;
    logic [MEM_AW-1:0] memWa;
    logic [7:0] memWd;
  } scw_dev_type;

  scw_dev_type r_r;
  scw_dev_type r_nxt;
  logic [7:0] mem [MEM_DEPTH];
  logic [7:0] memRd_r;

  // ==========================================================
  // clamp the oversample field to its legal range, plus one
  function automatic logic [4:0] clampFactor(input logic [3:0] f);
    logic [3:0] c;
    c = (f < FCT_FIELD_MIN) ? FCT_FIELD_MIN : f;
    clampFactor = {1'b0, c} + 5'h01;
  endfunction : clampFactor

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic [2:0] clean;
    logic selFall;
    logic rise;
    logic fall;
    logic lead;
    logic trail;
    logic smp;
    logic shf;
    logic cfgBad;
    logic deep;
    logic serve;
    logic refuse;
    logic [7:0] byteIn;
    logic [7:0] nextTx;
    logic [MEM_AW-1:0] nextPtr;
    r_nxt = r_r;
    clean = 3'h0;
    byteIn = 8'h00;
    nextTx = 8'h00;
    nextPtr = r_r.ptr;
    r_nxt.s1 = {link.sclk, link.sselN, link.mosi};
    r_nxt.s2 = r_r.s1;
    r_nxt.h1 = r_r.s2;
    r_nxt.h2 = r_r.h1;
    r_nxt.rxValid = 1'b0;
    r_nxt.memWe = 1'b0;
    clean = rxFilter ? scwMaj3(r_r.s2, r_r.h1, r_r.h2) : r_r.s2;
    r_nxt.prev = clean;
    selFall = r_r.prev[LN_SEL] & ~clean[LN_SEL];
    rise = ~r_r.prev[LN_SCLK] & clean[LN_SCLK];
    fall = r_r.prev[LN_SCLK] & ~clean[LN_SCLK];
    lead = cpol ? fall : rise;
    trail = cpol ? rise : fall;
    smp = cpha ? trail : lead;
    shf = cpha ? lead : trail;
    cfgBad = masterMode | (~memBufMode & operationClockSource)
           | (memBufMode & ~selectClockSource & operationClockSource);
    deep = (powerMode == PWR_DEEP);
    // internal operation stops in deep sleep
    serve = ~cfgBad & (~deep | operationClockSource);
    refuse = ~cfgBad & deep & ~operationClockSource & selectClockSource;
    // sticky wake cause, set beats clear
    r_nxt.wakeCause = (r_r.wakeCause & ~wakeClear)
                    | (selFall & selectClockSource & ~cfgBad);
    r_nxt.wakeIrq = r_nxt.wakeCause & wakeMask;
    r_nxt.factorInUse = masterMode ? clampFactor(oversampleFactor[FCT_LSB +: FCT_W]) : 5'h00;
    // late sampling only in master mode, zero from reset
    r_nxt.lateInUse = masterMode & lateSample;
    unique case (r_r.st)
      DS_IDLE:
      begin
        r_nxt.misoOe = 1'b0;
        if (selFall && serve)
        begin
          // memory mode starts with an address byte
          nextTx = memBufMode ? REFUSE_BYTE : txData;
          r_nxt.st = DS_XFER;
          r_nxt.bitCnt = 4'h0;
          r_nxt.addrPhase = memBufMode;
          r_nxt.wrXfer = 1'b0;
          r_nxt.txSh = nextTx;
          r_nxt.misoDrv = nextTx[7];
          r_nxt.misoOe = 1'b1;
        end
        else if (selFall && refuse && wakeMask)
        begin
          r_nxt.st = DS_REFUSE;
          r_nxt.misoDrv = REFUSE_BYTE[7];
          r_nxt.misoOe = 1'b1;
        end
      end
      DS_XFER:
      begin
        if (clean[LN_SEL])
        begin
          r_nxt.st = DS_IDLE;
          r_nxt.misoOe = 1'b0;
        end
        else if (smp)
        begin
          byteIn = {r_r.rxSh[6:0], clean[LN_MOSI]};
          r_nxt.rxSh = byteIn;
          r_nxt.bitCnt = r_r.bitCnt + 4'h1;
          if (r_r.bitCnt == BIT_LAST)
          begin
            r_nxt.bitCnt = 4'h0;
            if (r_r.addrPhase)
            begin
              nextPtr = byteIn[MEM_AW-1:0];
              r_nxt.wrXfer = byteIn[ADDR_WR_BIT];
              r_nxt.addrPhase = 1'b0;
              nextTx = mem[nextPtr];
            end
            else if (memBufMode)
            begin
              // write or read the addressed location, then advance
              r_nxt.memWe = r_r.wrXfer;
              r_nxt.memWa = r_r.ptr;
              r_nxt.memWd = byteIn;
              nextPtr = r_r.ptr + 5'h01;
              nextTx = mem[nextPtr];
            end
            else
            begin
              r_nxt.rxData = byteIn;
              r_nxt.rxValid = 1'b1;
              nextTx = txData;
            end
            r_nxt.ptr = nextPtr;
            r_nxt.txSh = nextTx;
            r_nxt.misoDrv = nextTx[7];
          end
        end
        else if (shf && r_r.bitCnt != 4'h0)
        begin
          r_nxt.txSh = {r_r.txSh[6:0], 1'b0};
          r_nxt.misoDrv = r_r.txSh[6];
        end
      end
      DS_REFUSE:
      begin
        r_nxt.misoDrv = 1'b1;
        if (clean[LN_SEL])
        begin
          r_nxt.st = DS_IDLE;
          r_nxt.misoOe = 1'b0;
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      r_r <= '0;
      r_r.s1 <= 3'h2;
      r_r.s2 <= 3'h2;
      r_r.h1 <= 3'h2;
      r_r.h2 <= 3'h2;
      r_r.prev <= 3'h2;
      r_r.st <= DS_IDLE;
    end
    else
    begin
      r_r <= r_nxt;
    end
  end

  // ==========================================================
  // buffer memory, link write wins over the user port
  always_ff @(posedge clk_sys)
  begin
    if (r_r.memWe)
    begin
      mem[r_r.memWa] <= r_r.memWd;
    end
    else if (memWr)
    begin
      mem[memAddr] <= memWrData;
    end
  end

  // user read data one cycle after the address
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      memRd_r <= 8'h00;
    end
    else
    begin
      memRd_r <= mem[memAddr];
    end
  end

  // outputs straight from flops
  assign link.misoDrv = r_r.misoDrv;
  assign link.misoOe = r_r.misoOe;
  assign wakeCause_r = r_r.wakeCause;
  assign wakeIrq_r = r_r.wakeIrq;
  assign rxData_r = r_r.rxData;
  assign rxValid_r = r_r.rxValid;
  assign memRdData_r = memRd_r;
  assign factorInUse_r = r_r.factorInUse;
  assign lateInUse_r = r_r.lateInUse;
endmodule : scw_device

// ===== hdl/scw_if.sv
// serial link between the external master and the slave device
// assumes: the miso line is pulled high when the slave does not drive it
`timescale 1ns/10ps
interface scw_if;
  logic sclk;
  logic sselN;
  logic mosi;
  logic misoDrv;
  logic misoOe;
  logic miso;
  // resolved miso wire with pull-up
  assign miso = misoOe ? misoDrv : 1'b1;
  modport dev (input sclk, input sselN, input mosi, output misoDrv, output misoOe);
  modport mst (output sclk, output sselN, output mosi, input miso);
endinterface : scw_if

// ===== hdl/scw_master.sv
// master end: register-driven byte transfers, sclk from a divider
// assumes: half period DIV of at least 8 clk_sys so the slave keeps up
`timescale 1ns/10ps
module scw_master
  import scw_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link
  scw_if.mst link,
  // register port
  input wire logic [1:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdData_r
);
  import scw_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic [2:0] ctrl;
    logic [7:0] div;
    logic [7:0] cnt;
    logic [4:0] edges;
    scw_mst_type st;
    logic sclk;
    logic sselN;
    logic mosi;
    logic [7:0] txSh;
    logic [7:0] rxSh;
    logic [7:0] rxData;
    logic [3:0] bits;
    logic [7:0] rdData;
  } scw_mreg_type;

  scw_mreg_type m_r;
  scw_mreg_type m_nxt;

  // ==========================================================
  // next-state logic
  always_comb
  begin
    logic cp;
    logic ch;
    logic lead;
    logic smp;
    logic [7:0] rxIn;
    m_nxt = m_r;
    lead = 1'b0;
    smp = 1'b0;
    cp = m_r.ctrl[CTRL_CPOL];
    ch = m_r.ctrl[CTRL_CPHA];
    rxIn = m_r.rxSh;
    // miso synchroniser
    m_nxt.s1 = link.miso;
    m_nxt.s2 = m_r.s1;
    m_nxt.sselN = ~m_r.ctrl[CTRL_SEL];
    // register reads answer one cycle later
    if (rd)
    begin
      unique case (addr)
        MR_CTRL: m_nxt.rdData = {5'h00, m_r.ctrl};
        MR_DIV: m_nxt.rdData = m_r.div;
        MR_DATA: m_nxt.rdData = m_r.rxData;
        MR_STAT: m_nxt.rdData = {7'h00, m_r.st == MS_RUN};
      endcase
    end
    if (wr && addr == MR_CTRL)
    begin
      m_nxt.ctrl = wrData[2:0];
    end
    if (wr && addr == MR_DIV)
    begin
      m_nxt.div = (wrData == 8'h00) ? 8'h01 : wrData;
    end
    unique case (m_r.st)
      MS_IDLE:
      begin
        m_nxt.sclk = m_nxt.ctrl[CTRL_CPOL];
        if (wr && addr == MR_DATA)
        begin
          m_nxt.st = MS_RUN;
          m_nxt.txSh = wrData;
          m_nxt.mosi = wrData[7];
          m_nxt.cnt = m_r.div;
          m_nxt.edges = EDGES_PER_BYTE;
          m_nxt.bits = 4'h0;
        end
      end
      MS_RUN:
      begin
        if (m_r.cnt == 8'h01)
        begin
          // leading toggles are the even counts left
          lead = ~m_r.edges[0];
          smp = ch ? ~lead : lead;
          m_nxt.cnt = m_r.div;
          m_nxt.sclk = ~m_r.sclk;
          m_nxt.edges = m_r.edges - 5'h01;
          if (smp)
          begin
            rxIn = {m_r.rxSh[6:0], m_r.s2};
            m_nxt.rxSh = rxIn;
            m_nxt.bits = m_r.bits + 4'h1;
          end
          else if (m_r.bits != 4'h0)
          begin
            m_nxt.txSh = {m_r.txSh[6:0], 1'b0};
            m_nxt.mosi = m_r.txSh[6];
          end
          if (m_r.edges == 5'h01)
          begin
            m_nxt.st = MS_IDLE;
            m_nxt.rxData = rxIn;
            m_nxt.sclk = cp;
          end
        end
        else
        begin
          m_nxt.cnt = m_r.cnt - 8'h01;
        end
      end
    endcase
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      m_r <= '0;
      m_r.s1 <= 1'b1;
      m_r.s2 <= 1'b1;
      m_r.div <= DIV_RESET;
      m_r.st <= MS_IDLE;
      m_r.sselN <= 1'b1;
    end
    else
    begin
      m_r <= m_nxt;
    end
  end

  // outputs straight from flops
  assign link.sclk = m_r.sclk;
  assign link.sselN = m_r.sselN;
  assign link.mosi = m_r.mosi;
  assign rdData_r = m_r.rdData;
endmodule : scw_master

// ===== hdl/scw_pkg.sv
// shared constants, state types and helpers for the serial slave with wake
// assumes: both ends run on clk_sys at 100 MHz
package scw_pkg;
  // ==========================================================
  // memory buffer and byte framing
  localparam int MEM_DEPTH = 32;
  localparam int MEM_AW = 5;
  localparam int ADDR_WR_BIT = 7;
  localparam logic [7:0] REFUSE_BYTE = 8'hff;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam int EXT_RATE_MHZ = 48;
  // ==========================================================
  // oversample field: factor minus one, bits [3:0]
  localparam int FCT_LSB = 0;
  localparam int FCT_W = 4;
  localparam logic [3:0] FCT_FIELD_MIN = 4'h3;
  localparam logic [3:0] FCT_FIELD_MAX = 4'hf;
  // ==========================================================
  // system power modes
  localparam logic [1:0] PWR_ACTIVE = 2'h0;
  localparam logic [1:0] PWR_SLEEP = 2'h1;
  localparam logic [1:0] PWR_DEEP = 2'h2;
  // ==========================================================
  // line positions inside the sampled vector
  localparam int LN_SCLK = 2;
  localparam int LN_SEL = 1;
  localparam int LN_MOSI = 0;
  // ==========================================================
  // master register map, fields and counts
  localparam logic [1:0] MR_CTRL = 2'h0;
  localparam logic [1:0] MR_DIV = 2'h1;
  localparam logic [1:0] MR_DATA = 2'h2;
  localparam logic [1:0] MR_STAT = 2'h3;
  localparam int CTRL_CPOL = 0;
  localparam int CTRL_CPHA = 1;
  localparam int CTRL_SEL = 2;
  localparam logic [7:0] DIV_RESET = 8'h08;
  localparam logic [4:0] EDGES_PER_BYTE = 5'h10;
  // ==========================================================
  // state encodings
  typedef enum logic [2:0] {
    DS_IDLE = 3'b001,
    DS_XFER = 3'b010,
    DS_REFUSE = 3'b100
  } scw_dst_type;
  typedef enum logic [1:0] {
    MS_IDLE = 2'b01,
    MS_RUN = 2'b10
  } scw_mst_type;
  // ==========================================================
  // bitwise three-tap majority
  function automatic logic [2:0] scwMaj3(input logic [2:0] a, input logic [2:0] b,
                                         input logic [2:0] c);
    scwMaj3 = (a & b) | (a & c) | (b & c);
  endfunction : scwMaj3
endpackage : scw_pkg

// ===== tb/scw_checker.sv
// checker: timing relations on the serial link between both ends
// assumes: instantiated in the bench top beside the link interface
`timescale 1ns/10ps
module scw_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // link lines
  input wire logic sclk,
  input wire logic sselN,
  input wire logic misoDrv,
  input wire logic misoOe,
  input wire logic miso
);
  logic sclkPrev_r;
  logic sselPrev_r;
  logic [4:0] edgeCnt_r;
  logic [3:0] sinceEdge_r;
  // ==========================================================
  // helpers: sclk edges in a selection, cycles since last edge
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      sclkPrev_r <= 1'b0;
      sselPrev_r <= 1'b1;
      edgeCnt_r <= 5'h00;
      sinceEdge_r <= 4'h0;
    end
    else
    begin
      sclkPrev_r <= sclk;
      sselPrev_r <= sselN;
      if (sselN)
        edgeCnt_r <= 5'h00;
      else if (sclk != sclkPrev_r)
        edgeCnt_r <= edgeCnt_r + 5'h01;
      if (sclk != sclkPrev_r || sselN != sselPrev_r)
        sinceEdge_r <= 4'h0;
      else if (sinceEdge_r != 4'hf)
        sinceEdge_r <= sinceEdge_r + 4'h1;
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_desel; $rose(sselN); endsequence
  sequence s_release; ##[1:8] !misoOe; endsequence
  property p_oe_release; s_desel |-> s_release; endproperty
  property p_no_oe_idle; sselN [*8] |-> !misoOe; endproperty
  property p_oe_rise_sel; $rose(misoOe) |-> !sselN && !$past(sselN); endproperty
  property p_miso_pullup; !misoOe |-> miso; endproperty
  property p_sclk_half; $changed(sclk) |=> $stable(sclk) [*7]; endproperty
  property p_edges_byte; s_desel |-> edgeCnt_r[3:0] == 4'h0; endproperty
  property p_miso_timing;
    misoOe && $past(misoOe) && $changed(misoDrv) |-> sinceEdge_r <= 4'ha;
  endproperty
  property p_desel_idle; s_desel |-> $stable(sclk); endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("miso enable held after deselect");
  a_no_oe_idle: assert property (p_no_oe_idle)
    else $error("miso driven while not selected");
  a_oe_rise_sel: assert property (p_oe_rise_sel)
    else $error("miso enable rose without selection");
  a_miso_pullup: assert property (p_miso_pullup)
    else $error("released miso not high");
  a_sclk_half: assert property (p_sclk_half)
    else $error("sclk half period too short");
  a_edges_byte: assert property (p_edges_byte)
    else $error("sclk edge count not whole bytes");
  a_miso_timing: assert property (p_miso_timing)
    else $error("miso changed far from an sclk edge");
  a_desel_idle: assert property (p_desel_idle)
    else $error("sclk moved at deselect");
endmodule : scw_checker

// ===== tb/tb_top.sv
// bench: master and slave ends joined by the link, driven by scenarios
// assumes: 100 MHz clk_sys, master divider makes the serial clock
`timescale 1ns/10ps
module tb_top;
  import scw_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic masterMode = 1'b0, memBufMode = 1'b0, selectClockSource = 1'b0;
  logic operationClockSource = 1'b0, lateSample = 1'b0, rxFilter = 1'b0;
  logic cpol = 1'b0, cpha = 1'b0, wakeMask = 1'b0, wakeClear = 1'b0, memWr = 1'b0;
  logic [3:0] oversampleFactor = 4'h0;
  logic [1:0] powerMode = 2'h0, addr = 2'h0;
  logic [7:0] txData = 8'h00, memWrData = 8'h00, wrData = 8'h00;
  logic [4:0] memAddr = 5'h00;
  logic wr = 1'b0, rd = 1'b0;
  logic wakeCause, wakeIrq, rxValid, lateInUse;
  logic [7:0] rxData, memRdData, rdData;
  logic [4:0] factorInUse;
  int err_count = 0, checked = 0, rxCount = 0;
  // ==========================================================
  // design ends and link checker
  scw_if i_scw_if ();
  scw_device i_scw_device (.clk_sys(clk_sys), .rst(rst), .link(i_scw_if),
    .masterMode(masterMode), .memBufMode(memBufMode), .selectClockSource(selectClockSource),
    .operationClockSource(operationClockSource), .oversampleFactor(oversampleFactor),
    .lateSample(lateSample), .rxFilter(rxFilter), .cpol(cpol), .cpha(cpha),
    .powerMode(powerMode), .wakeMask(wakeMask), .wakeClear(wakeClear),
    .wakeCause_r(wakeCause), .wakeIrq_r(wakeIrq), .txData(txData), .rxData_r(rxData),
    .rxValid_r(rxValid), .memAddr(memAddr), .memWrData(memWrData), .memWr(memWr),
    .memRdData_r(memRdData), .factorInUse_r(factorInUse), .lateInUse_r(lateInUse));
  scw_master i_scw_master (.clk_sys(clk_sys), .rst(rst), .link(i_scw_if), .addr(addr),
    .wrData(wrData), .wr(wr), .rd(rd), .rdData_r(rdData));
  scw_checker i_scw_checker (.clk_sys(clk_sys), .rst(rst), .sclk(i_scw_if.sclk),
    .sselN(i_scw_if.sselN), .misoDrv(i_scw_if.misoDrv), .misoOe(i_scw_if.misoOe),
    .miso(i_scw_if.miso));
  // clock and received byte pulse count
  initial
    forever #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    if (rxValid === 1'b1)
      rxCount++;
  // ==========================================================
  // shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic give_verdict;
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict
  task automatic busWr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    wrData <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : busWr
  task automatic busRd(input logic [1:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdData;
  endtask : busRd
  task automatic cfg(input logic [5:0] c, input logic [1:0] pm);
    @(posedge clk_sys);
    {masterMode, memBufMode, selectClockSource, operationClockSource, wakeMask, rxFilter} <= c;
    powerMode <= pm;
  endtask : cfg
  task automatic linkSel(input logic on, input logic [1:0] m);
    @(posedge clk_sys);
    cpol <= m[0];
    cpha <= m[1];
    busWr(MR_CTRL, {5'h00, on, m});
    repeat (12) @(posedge clk_sys);
  endtask : linkSel
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [7:0] st;
    busWr(MR_DATA, tx);
    st = 8'h01;
    for (int i = 0; i < 400 && st[0] !== 1'b0; i++)
      busRd(MR_STAT, st);
    if (st[0] !== 1'b0)
    begin
      err_count++;
      give_verdict();
    end
    busRd(MR_DATA, rx);
  endtask : xfer
  task automatic run(input logic [1:0] m, input logic [7:0] tx, output logic [7:0] rx);
    linkSel(1'b0, m);
    linkSel(1'b1, m);
    xfer(tx, rx);
    linkSel(1'b0, m);
  endtask : run
  task automatic clearWake;
    @(posedge clk_sys);
    wakeClear <= 1'b1;
    @(posedge clk_sys);
    wakeClear <= 1'b0;
  endtask : clearWake
  // ==========================================================
  // scenarios
  task automatic t_factor;
    cfg(6'h20, PWR_ACTIVE);
    for (int f = 0; f < 16; f += 3)
    begin
      @(posedge clk_sys);
      oversampleFactor <= 4'(f);
      lateSample <= f[0];
      repeat (2) @(posedge clk_sys);
      #1;
      check("factor", {3'h0, factorInUse}, (f < 3) ? 8'h04 : 8'(f + 1));
      check("late", {7'h00, lateInUse}, 8'(f & 1));
    end
    cfg(6'h00, PWR_ACTIVE);
    repeat (2) @(posedge clk_sys);
    #1;
    check("factor slave", {3'h0, factorInUse}, 8'h00);
  endtask : t_factor
  task automatic t_stream;
    logic [7:0] rx;
    int n;
    for (int m = 0; m < 4; m++)
    begin
      n = rxCount;
      txData <= 8'ha5 ^ 8'(m);
      run(2'(m), 8'h3c + 8'(m), rx);
      check("stream miso", rx, 8'ha5 ^ 8'(m));
      check("stream mosi", rxData, 8'h3c + 8'(m));
      check("rx pulses", 8'(rxCount - n), 8'h01);
    end
    cfg(6'h01, PWR_ACTIVE);
    busWr(MR_DIV, 8'h0a);
    txData <= 8'hc6;
    run(2'h3, 8'h6b, rx);
    check("filter miso", rx, 8'hc6);
    check("filter mosi", rxData, 8'h6b);
    busWr(MR_DIV, DIV_RESET);
  endtask : t_stream
  task automatic t_mem;
    logic [7:0] rx;
    cfg(6'h1c, PWR_DEEP);
    @(posedge clk_sys);
    memAddr <= 5'h06;
    memWrData <= 8'hc3;
    memWr <= 1'b1;
    @(posedge clk_sys);
    memWr <= 1'b0;
    linkSel(1'b1, 2'h0);
    xfer(8'h85, rx);
    check("mem cmd", rx, REFUSE_BYTE);
    xfer(8'h5a, rx);
    linkSel(1'b0, 2'h0);
    linkSel(1'b1, 2'h0);
    xfer(8'h05, rx);
    xfer(8'h00, rx);
    check("mem rd a", rx, 8'h5a);
    xfer(8'h00, rx);
    check("mem rd b", rx, 8'hc3);
    linkSel(1'b0, 2'h0);
    memAddr <= 5'h05;
    @(posedge clk_sys);
    #1;
    check("user rd", memRdData, 8'h5a);
  endtask : t_mem
  task automatic t_wake;
    logic [7:0] rx;
    clearWake();
    cfg(6'h0a, PWR_DEEP);
    txData <= 8'h00;
    run(2'h0, 8'h12, rx);
    check("refuse", rx, REFUSE_BYTE);
    check("cause", {7'h00, wakeCause}, 8'h01);
    check("irq", {7'h00, wakeIrq}, 8'h01);
    clearWake();
    #1;
    check("cleared", {7'h00, wakeCause}, 8'h00);
    cfg(6'h08, PWR_ACTIVE);
    txData <= 8'h77;
    run(2'h1, 8'h21, rx);
    check("active xfer", rx, 8'h77);
    check("cause act", {7'h00, wakeCause}, 8'h01);
    check("irq masked", {7'h00, wakeIrq}, 8'h00);
  endtask : t_wake
  task automatic t_refuse;
    logic [5:0] cs [4] = '{6'h20, 6'h14, 6'h00, 6'h04};
    logic [1:0] ps [4] = '{PWR_ACTIVE, PWR_ACTIVE, PWR_DEEP, PWR_ACTIVE};
    logic [7:0] rx;
    for (int i = 0; i < 4; i++)
    begin
      clearWake();
      cfg(cs[i], ps[i]);
      txData <= 8'h00;
      run(2'h0, 8'h99, rx);
      check("no answer", rx, REFUSE_BYTE);
      check("no wake", {7'h00, wakeCause}, 8'h00);
    end
  endtask : t_refuse
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    check("late reset", {7'h00, lateInUse}, 8'h00);
    t_factor();
    t_stream();
    t_mem();
    t_wake();
    t_refuse();
    give_verdict();
  end
endmodule : tb_top
